// ===== design/ihc_ctl.sv
`timescale 1ns/1ps

module ihc_ctl
   import ihc_pkg::*;
#(
   parameter bit HOST_PORT_OPT = 1'b1,
   parameter bit REDUCED_PINS  = 1'b0,
   parameter bit AUX_IS_INPUT  = 1'b0
)
(
   input  wire logic                clock,
   input  wire logic                srst,
   input  wire logic                reset_n,
   input  wire ihc_osc_mode_e       osc_mode,
   input  wire ihc_div_sel_e        div_sel,
   input  wire logic                osc_aux_pin,
   input  wire logic                strobe_or_irq_input,
   input  wire logic                select_input,
   input  wire logic                write_strobe_input,
   input  wire logic [BYTE_W-1:0]   port_in,
   output logic      [BYTE_W-1:0]   port_out,
   output logic      [BYTE_W-1:0]   port_oe,
   output logic                     host_ready_out,
   output logic                     sync_clock_out,
   output logic                     cycle_strobe,
   input  wire logic                instr_done,
   input  wire logic                instr_is_chain,
   input  wire logic                instr_skip,
   input  wire logic                stack_pop_op,
   input  wire logic                latch_read_op,
   input  wire logic                load_enables_op,
   input  wire logic [NIB_W-1:0]    enables_value,
   input  wire logic                latch_load,
   input  wire logic [BYTE_W-1:0]   latch_value,
   input  wire logic                ready_write_one,
   input  wire logic                sync_enable_set,
   input  wire logic                sync_enable_clear,
   output logic      [PC_W-1:0]     pc,
   output logic      [NIB_W-1:0]    enables,
   output logic                     skip_restore,
   output logic      [NIB_W-1:0]    latch_read_value,
   output logic                     init_active,
   output logic                     irq_ack,
   output logic      [BYTE_W-1:0]   rx_data,
   output logic                     rx_valid,
   input  wire logic                rx_ready,
   output logic                     rx_overrun
);

   typedef struct packed
   {
      ihc_state_e              state;
      logic [4:0]              div_cnt;
      logic [1:0]              rst_cnt;
      logic [1:0]              irq_cnt;
      logic                    irq_prev;
      logic                    irq_armed;
      logic [PC_W-1:0]         pc;
      logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
      logic                    skip_saved;
      logic                    skip_restore;
      logic [NIB_W-1:0]        en;
      logic [BYTE_W-1:0]       latch;
      logic                    ready;
      logic                    wr_prev;
      logic                    sync_on;
      logic                    sync_out;
      logic                    aux_prev;
      logic [NIB_W-1:0]        il_value;
      logic                    overrun;
   } ihc_ctl_s;

   ihc_ctl_s st_r;
   ihc_ctl_s st_nxt;

   ////////////////////////////////////////////////////////////////////////////

   function automatic logic [4:0] div_ratio(input ihc_osc_mode_e m, input ihc_div_sel_e s);
      logic [4:0] r;
      r = DIV_16;
      case (m)
         IHC_OSC_CRYSTAL:  r = (s == IHC_DIVSEL_BASE) ? DIV_16 : DIV_8;
         IHC_OSC_EXTERNAL: r = (s == IHC_DIVSEL_ALT8) ? DIV_8 :
                               (s == IHC_DIVSEL_ALT4) ? DIV_4 : DIV_16;
         IHC_OSC_RC:       r = DIV_4;
         default:          r = DIV_16;
      endcase
      return r;
   endfunction
   // Host-port strobes, decoded once and reused
   logic host_mode;
   logic host_sel;
   logic host_rd;
   logic host_wr;
   logic cyc_tick;
   logic wr_fall;
   logic irq_fall;
   logic fifo_in_ready;

   assign host_mode = HOST_PORT_OPT && !REDUCED_PINS;
   assign host_sel  = host_mode && !select_input;
   assign host_rd   = host_sel && !strobe_or_irq_input;
   assign host_wr   = host_sel && !write_strobe_input;
   assign wr_fall   = host_wr && !st_r.wr_prev;

   // Synced mode: each sync pulse on the aux pin ends one cycle
   assign cyc_tick = (osc_mode == IHC_OSC_SYNCED) ? (osc_aux_pin && !st_r.aux_prev)
                                                  : (st_r.div_cnt == 5'h00);

   // Irq input only exists when not used as read strobe
   assign irq_fall = !host_mode && !REDUCED_PINS && st_r.irq_prev && !strobe_or_irq_input;

   ////////////////////////////////////////////////////////////////////////////

   always_comb
   begin
      st_nxt          = st_r;
      st_nxt.aux_prev = osc_aux_pin;
      st_nxt.wr_prev  = host_wr;
      st_nxt.skip_restore = 1'b0;
      st_nxt.div_cnt  = cyc_tick ? div_ratio(osc_mode, div_sel) - 5'h01 : st_r.div_cnt - 5'h01;
      st_nxt.sync_out = cyc_tick && st_r.sync_on;

      // Reset low counted in instruction cycles
      if (reset_n)
      begin
         st_nxt.rst_cnt = '0;
      end
      else if (cyc_tick && st_r.rst_cnt != RST_LOW_CYCLES)
      begin
         st_nxt.rst_cnt = st_r.rst_cnt + 2'h1;
      end

      if (cyc_tick)
      begin
         st_nxt.irq_prev = strobe_or_irq_input;
         if (strobe_or_irq_input)
         begin
            st_nxt.irq_cnt = '0;
         end
         else if (irq_fall || st_r.irq_cnt != '0)
         begin
            if (st_r.irq_cnt != IRQ_LOW_CYCLES)
            begin
               st_nxt.irq_cnt = st_r.irq_cnt + 2'h1;
            end
            if (st_r.irq_cnt + 2'h1 == IRQ_LOW_CYCLES && st_r.en[EN_IRQ_BIT])
            begin
               st_nxt.irq_armed = 1'b1;
            end
         end
      end

      if (sync_enable_set)
      begin
         st_nxt.sync_on = 1'b1;
      end
      else if (sync_enable_clear)
      begin
         st_nxt.sync_on = 1'b0;
      end

      if (load_enables_op)
      begin
         st_nxt.en = enables_value;
      end
      if (latch_load)
      begin
         st_nxt.latch = latch_value;
      end
      if (host_wr)
      begin
         st_nxt.latch = port_in;
      end

      // Program set and host clear: host write is the later event, clear wins
      if (ready_write_one)
      begin
         st_nxt.ready = 1'b1;
      end
      if (wr_fall)
      begin
         st_nxt.ready = 1'b0;
      end
      if (wr_fall && !fifo_in_ready)
      begin
         st_nxt.overrun = 1'b1;
      end

      if (latch_read_op)
      begin
         st_nxt.il_value = '0;
         st_nxt.il_value[AUX_ACC_BIT] = AUX_IS_INPUT ? osc_aux_pin : 1'b0;
      end

      case (st_r.state)
         IHC_ST_RUN:
         begin
            if (instr_done)
            begin
               st_nxt.pc = st_r.pc + 10'h001;
               if (stack_pop_op)
               begin
                  st_nxt.pc           = st_r.stack[0];
                  st_nxt.stack        = {st_r.stack[STACK_DEPTH-1], st_r.stack[STACK_DEPTH-1:1]};
                  st_nxt.skip_restore = st_r.skip_saved;
                  st_nxt.skip_saved   = 1'b0;
               end
               if (st_r.irq_armed && !instr_is_chain)
               begin
                  st_nxt.state = IHC_ST_ACK;
               end
            end
         end
         IHC_ST_ACK:
         begin
            st_nxt.stack      = {st_r.stack[STACK_DEPTH-2:0], st_r.pc};
            st_nxt.pc         = IRQ_VECTOR;
            st_nxt.en[EN_IRQ_BIT] = 1'b0;
            st_nxt.skip_saved = instr_skip;
            st_nxt.irq_armed  = 1'b0;
            st_nxt.state      = IHC_ST_RUN;
         end
         IHC_ST_RESET:
         begin
            if (reset_n)
            begin
               st_nxt.state = IHC_ST_RUN;
            end
         end
         default:
         begin
            st_nxt.state = IHC_ST_RUN;
         end
      endcase

      // Stack contents survive init as data RAM does; the latch is cleared
      if (st_nxt.rst_cnt == RST_LOW_CYCLES)
      begin
         st_nxt.state     = IHC_ST_RESET;
         st_nxt.pc        = RESET_PC;
         st_nxt.en        = '0;
         st_nxt.latch     = '0;
         st_nxt.ready     = 1'b0;
         st_nxt.irq_armed = 1'b0;
         st_nxt.sync_on   = 1'b1;
      end
   end
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         st_r         <= '0;
         st_r.state   <= IHC_ST_RESET;
         st_r.sync_on <= 1'b1;
         st_r.irq_prev <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   // Host strobes own the port direction in host mode
   always_comb
   begin
      port_out = st_r.latch;
      if (host_mode)
      begin
         port_oe = {BYTE_W{host_rd}};
      end
      else
      begin
         port_oe = {BYTE_W{st_r.en[EN_DRIVE_BIT]}};
      end
   end
   // Received bytes queue so slow firmware does not lose a burst
   ihc_fifo #(
      .WIDTH (BYTE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .clock     (clock),
      .srst      (srst),
      .in_data   (port_in),
      .in_valid  (wr_fall),
      .in_ready  (fifo_in_ready),
      .out_data  (rx_data),
      .out_valid (rx_valid),
      .out_ready (rx_ready)
   );
   assign host_ready_out   = host_mode ? st_r.ready : 1'b0;
   assign sync_clock_out   = st_r.sync_out;
   assign cycle_strobe     = cyc_tick;
   assign pc               = st_r.pc;
   assign enables          = st_r.en;
   assign skip_restore     = st_r.skip_restore;
   assign latch_read_value = st_r.il_value;
   assign init_active      = (st_r.state == IHC_ST_RESET);
   assign irq_ack          = (st_r.state == IHC_ST_ACK);
   assign rx_overrun       = st_r.overrun;

   ////////////////////////////////////////////////////////////////////////////

   property p_vector;
      @(posedge clock) disable iff (srst)
      (st_r.state == IHC_ST_ACK) && (st_nxt.state != IHC_ST_RESET) |=> (pc == IRQ_VECTOR) && !enables[EN_IRQ_BIT];
   endproperty
   a_vector: assert property (p_vector) else $error("Vector or enable wrong after ack");
   property p_push;
      @(posedge clock) disable iff (srst)
      (st_r.state == IHC_ST_ACK) && (st_nxt.state != IHC_ST_RESET) |=> st_r.stack[0] == $past(pc);
   endproperty
   a_push: assert property (p_push) else $error("Return address not pushed");
   property p_chain;
      @(posedge clock) disable iff (srst)
      (st_r.state == IHC_ST_RUN) && instr_is_chain |=> (st_r.state != IHC_ST_ACK);
   endproperty
   a_chain: assert property (p_chain) else $error("Ack inside jump chain");
   property p_read_drive;
      @(posedge clock) disable iff (srst)
      host_rd |-> (port_oe == {BYTE_W{1'b1}}) && (port_out == st_r.latch);
   endproperty
   a_read_drive: assert property (p_read_drive) else $error("Read strobe not driving latch");
   property p_write_cap;
      @(posedge clock) disable iff (srst)
      host_wr && (st_nxt.rst_cnt != RST_LOW_CYCLES) |=> st_r.latch == $past(port_in);
   endproperty
   a_write_cap: assert property (p_write_cap) else $error("Write strobe did not capture");
   property p_unsel;
      @(posedge clock) disable iff (srst)
      host_mode && select_input |-> port_oe == '0;
   endproperty
   a_unsel: assert property (p_unsel) else $error("Port driven while deselected");
   property p_ready_clr;
      @(posedge clock) disable iff (srst)
      wr_fall |=> !host_ready_out;
   endproperty
   a_ready_clr: assert property (p_ready_clr) else $error("Ready not cleared by write");
   property p_init;
      @(posedge clock) disable iff (srst)
      st_nxt.rst_cnt == RST_LOW_CYCLES |=> (pc == RESET_PC) && (enables == '0) && init_active;
   endproperty
   a_init: assert property (p_init) else $error("Init did not clear state");
endmodule

// ===== design/ihc_pkg.sv
package ihc_pkg;

   // Data and address widths, stack and FIFO depths
   localparam int unsigned PC_W        = 10;
   localparam int unsigned STACK_DEPTH = 3;
   localparam int unsigned BYTE_W      = 8;
   localparam int unsigned NIB_W       = 4;
   localparam int unsigned FIFO_DEPTH  = 32;

   // Addresses
   localparam logic [9:0] IRQ_VECTOR = 10'h0FF;
   localparam logic [9:0] RESET_PC   = 10'h000;

   // Least widths, in instruction cycles
   localparam logic [1:0] IRQ_LOW_CYCLES = 2'h2;
   localparam logic [1:0] RST_LOW_CYCLES = 2'h2;

   // Divider ratios
   localparam logic [4:0] DIV_16 = 5'h10;
   localparam logic [4:0] DIV_8  = 5'h08;
   localparam logic [4:0] DIV_4  = 5'h04;

   // Enable register bit positions
   localparam int unsigned EN_IRQ_BIT   = 1;
   localparam int unsigned EN_DRIVE_BIT = 2;

   // Accumulator bit for the auxiliary oscillator pin
   localparam int unsigned AUX_ACC_BIT = 2;

   typedef enum logic [1:0]
   {
      IHC_OSC_CRYSTAL,
      IHC_OSC_EXTERNAL,
      IHC_OSC_RC,
      IHC_OSC_SYNCED
   } ihc_osc_mode_e;

   typedef enum logic [1:0]
   {
      IHC_DIVSEL_BASE,
      IHC_DIVSEL_ALT8,
      IHC_DIVSEL_ALT4
   } ihc_div_sel_e;

   typedef enum logic [1:0]
   {
      IHC_ST_RUN,
      IHC_ST_RESET,
      IHC_ST_ACK
   } ihc_state_e;

endpackage

// ===== design/ihc_fifo.sv
`timescale 1ns/1ps

module ihc_fifo
   import ihc_pkg::*;
#(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 32
)
(
   input  wire logic             clock,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);

   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed
   {
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0]   count;
   } ihc_fifo_s;

   ihc_fifo_s st_r;
   ihc_fifo_s st_nxt;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   assign in_ready  = (st_r.count != (AW+1)'(DEPTH));
   assign out_valid = (st_r.count != '0);
   assign out_data  = mem[st_r.rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb
   begin
      st_nxt = st_r;
      if (push)
      begin
         st_nxt.wr_ptr = (st_r.wr_ptr == AW'(DEPTH-1)) ? '0 : st_r.wr_ptr + 1'b1;
      end
      if (pop)
      begin
         st_nxt.rd_ptr = (st_r.rd_ptr == AW'(DEPTH-1)) ? '0 : st_r.rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
         st_nxt.count = st_r.count + 1'b1;
      end
      else if (pop && !push)
      begin
         st_nxt.count = st_r.count - 1'b1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
      if (push)
      begin
         mem[st_r.wr_ptr] <= in_data;
      end
   end

endmodule

// ===== tb/ihc_host_model.sv
`timescale 1ns/1ps

module ihc_host_model
   import ihc_pkg::*;
(
   input  wire logic              clock,
   output logic                   rd_n,
   output logic                   cs_n,
   output logic                   wr_n,
   output logic      [BYTE_W-1:0] drv_data,
   input  wire logic [BYTE_W-1:0] bus_level
);

   initial
   begin
      rd_n     = 1'b1;
      cs_n     = 1'b1;
      wr_n     = 1'b1;
      drv_data = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write: byte held for two edges, then write strobe and select released together
   task automatic write_byte(input logic [BYTE_W-1:0] d, input logic sel);
   begin
      @(posedge clock);
      #1;
      cs_n     = ~sel;
      wr_n     = 1'b0;
      drv_data = d;
      repeat (2) @(posedge clock);
      #1;
      wr_n     = 1'b1;
      cs_n     = 1'b1;
      // Released bus must not keep showing the byte
      drv_data = ~d;
   end
   endtask

   // Read: data taken at the edge, released just after it
   task automatic read_byte(output logic [BYTE_W-1:0] d);
   begin
      @(posedge clock);
      #1;
      cs_n = 1'b0;
      rd_n = 1'b0;
      @(posedge clock);
      d = bus_level;
      #1;
      rd_n = 1'b1;
      cs_n = 1'b1;
   end
   endtask

endmodule

// ===== tb/ihc_ctl_tb.sv
`timescale 1ns/1ps

module ihc_ctl_tb;
   import ihc_pkg::*;

   logic                clock, srst, reset_n, osc_aux_pin, rd_n, cs_n, wr_n;
   ihc_osc_mode_e       osc_mode;
   ihc_div_sel_e        div_sel;
   logic [BYTE_W-1:0]   host_data, port_in, port_out, port_oe, latch_value, rx_data, rd_val;
   logic                host_ready_out, sync_clock_out, cycle_strobe, skip_restore, init_active, irq_ack;
   logic                instr_done, instr_is_chain, instr_skip, stack_pop_op, latch_read_op, load_enables_op;
   logic                latch_load, ready_write_one, sync_enable_set, sync_enable_clear;
   logic                rx_valid, rx_ready, rx_overrun;
   logic [NIB_W-1:0]    enables_value, enables, latch_read_value;
   logic [PC_W-1:0]     pc;
   logic [PC_W-1:0]     pc_irq;
   logic [NIB_W-1:0]    en_irq;
   logic [BYTE_W-1:0]   oe_irq;
   logic                irq_n, ack_irq, skip_irq;
   logic [BYTE_W-1:0]   exp_q[$];
   int                  err_count, n_checks, cycles, k, gap;
   ihc_osc_mode_e       mode_tab[6] = '{IHC_OSC_CRYSTAL, IHC_OSC_CRYSTAL, IHC_OSC_EXTERNAL,
                                        IHC_OSC_EXTERNAL, IHC_OSC_EXTERNAL, IHC_OSC_RC};
   ihc_div_sel_e        sel_tab[6]  = '{IHC_DIVSEL_BASE, IHC_DIVSEL_ALT8, IHC_DIVSEL_BASE,
                                        IHC_DIVSEL_ALT8, IHC_DIVSEL_ALT4, IHC_DIVSEL_BASE};
   int                  div_tab[6]  = '{16, 8, 16, 8, 4, 4};

   // Undriven bits show the host's floating pattern
   assign port_in = (port_oe & port_out) | (~port_oe & host_data);

   ihc_ctl #(.HOST_PORT_OPT(1'b1), .REDUCED_PINS(1'b0), .AUX_IS_INPUT(1'b1)) i_ihc_ctl
   (
      .clock(clock), .srst(srst), .reset_n(reset_n), .osc_mode(osc_mode), .div_sel(div_sel),
      .osc_aux_pin(osc_aux_pin), .strobe_or_irq_input(rd_n), .select_input(cs_n),
      .write_strobe_input(wr_n), .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
      .host_ready_out(host_ready_out), .sync_clock_out(sync_clock_out), .cycle_strobe(cycle_strobe),
      .instr_done(instr_done), .instr_is_chain(instr_is_chain), .instr_skip(instr_skip),
      .stack_pop_op(stack_pop_op), .latch_read_op(latch_read_op), .load_enables_op(load_enables_op),
      .enables_value(enables_value), .latch_load(latch_load), .latch_value(latch_value),
      .ready_write_one(ready_write_one), .sync_enable_set(sync_enable_set),
      .sync_enable_clear(sync_enable_clear), .pc(pc), .enables(enables), .skip_restore(skip_restore),
      .latch_read_value(latch_read_value), .init_active(init_active), .irq_ack(irq_ack),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_overrun(rx_overrun)
   );

   // Copy without the host option, so the shared pin acts as interrupt input
   ihc_ctl #(.HOST_PORT_OPT(1'b0), .REDUCED_PINS(1'b0), .AUX_IS_INPUT(1'b0)) i_ihc_ctl_irq
   (
      .clock(clock), .srst(srst), .reset_n(reset_n), .osc_mode(osc_mode), .div_sel(div_sel),
      .osc_aux_pin(osc_aux_pin), .strobe_or_irq_input(irq_n), .select_input(1'b1),
      .write_strobe_input(1'b1), .port_in(8'h00), .port_out(), .port_oe(oe_irq),
      .host_ready_out(), .sync_clock_out(), .cycle_strobe(),
      .instr_done(instr_done), .instr_is_chain(instr_is_chain), .instr_skip(instr_skip),
      .stack_pop_op(stack_pop_op), .latch_read_op(latch_read_op), .load_enables_op(load_enables_op),
      .enables_value(enables_value), .latch_load(latch_load), .latch_value(latch_value),
      .ready_write_one(ready_write_one), .sync_enable_set(sync_enable_set),
      .sync_enable_clear(sync_enable_clear), .pc(pc_irq), .enables(en_irq), .skip_restore(skip_irq),
      .latch_read_value(), .init_active(), .irq_ack(ack_irq),
      .rx_data(), .rx_valid(), .rx_ready(1'b0), .rx_overrun()
   );

   ihc_host_model i_ihc_host_model
   (
      .clock(clock), .rd_n(rd_n), .cs_n(cs_n), .wr_n(wr_n), .drv_data(host_data), .bus_level(port_in)
   );

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      if (err_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // First pass aligns to a pulse, second gives the spacing in clocks
   task automatic measure(input bit use_sync, output int g);
      for (int p = 0; p < 2; p++)
      begin
         g = 0;
         do
         begin
            @(posedge clock);
            g++;
         end
         while (((use_sync ? sync_clock_out : cycle_strobe) !== 1'b1) && g < 100);
      end
      #1;
   endtask

   // FIFO overflow only flags, so the model stops queueing at depth
   task automatic hwrite(input logic [BYTE_W-1:0] d);
      i_ihc_host_model.write_byte(d, 1'b1);
      if (exp_q.size() < FIFO_DEPTH)
         exp_q.push_back(d);
   endtask

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         err_count++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {srst, reset_n} = 2'b11;
      {osc_aux_pin, instr_done, instr_is_chain, instr_skip, stack_pop_op} = 5'h00;
      {latch_read_op, load_enables_op, latch_load, ready_write_one} = 4'h0;
      {sync_enable_set, sync_enable_clear, rx_ready, irq_n} = 4'h1;
      osc_mode      = IHC_OSC_CRYSTAL;
      div_sel       = IHC_DIVSEL_BASE;
      enables_value = 4'h0;
      latch_value   = 8'h00;
      tick(16);
      srst = 1'b0;
      for (k = 0; k < 100 && init_active !== 1'b0; k++) tick(1);
      chk("pc", 32'(pc), 32'(RESET_PC));
      chk("enables", 32'(enables), 32'h0);
      for (k = 0; k < 6; k++)
      begin
         osc_mode = mode_tab[k];
         div_sel  = sel_tab[k];
         measure(1'b0, gap);
         chk("cycle gap", 32'(gap), 32'(div_tab[k]));
         measure(1'b1, gap);
         chk("sync gap", 32'(gap), 32'(div_tab[k]));
      end
      // Synced mode: one cycle per rising edge on the aux pin
      osc_mode = IHC_OSC_SYNCED;
      gap      = 0;
      for (k = 0; k < 30; k++)
      begin
         osc_aux_pin = (k % 5 == 0);
         @(posedge clock);
         gap += int'(cycle_strobe === 1'b1);
         #1;
      end
      chk("synced ticks", 32'(gap), 32'h6);
      osc_mode = IHC_OSC_CRYSTAL;
      div_sel  = IHC_DIVSEL_BASE;
      // Host port: latch readback, drive enable ignored
      latch_value = 8'h3C;
      latch_load  = 1'b1;
      tick(1);
      latch_load = 1'b0;
      i_ihc_host_model.read_byte(rd_val);
      chk("host read", 32'(rd_val), 32'h3C);
      enables_value   = 4'h4;
      load_enables_op = 1'b1;
      tick(1);
      load_enables_op = 1'b0;
      tick(1);
      chk("enables", 32'(enables), 32'h4);
      chk("port_oe idle", 32'(port_oe), 32'h0);
      chk("port_oe plain", 32'(oe_irq), 32'hFF);
      hwrite(8'hA5);
      chk("latch", 32'(port_out), 32'hA5);
      chk("ready", 32'(host_ready_out), 32'h0);
      ready_write_one = 1'b1;
      tick(1);
      ready_write_one = 1'b0;
      tick(1);
      chk("ready", 32'(host_ready_out), 32'h1);
      i_ihc_host_model.write_byte(8'h5A, 1'b0);
      chk("latch", 32'(port_out), 32'hA5);
      chk("ready", 32'(host_ready_out), 32'h1);
      i_ihc_host_model.read_byte(rd_val);
      chk("host read", 32'(rd_val), 32'hA5);
      // Fill the receive FIFO past its depth, then drain it
      for (k = 1; exp_q.size() < FIFO_DEPTH; k++) hwrite(8'(k * 7));
      chk("overrun", 32'(rx_overrun), 32'h0);
      hwrite(8'hEE);
      chk("overrun", 32'(rx_overrun), 32'h1);
      while (exp_q.size() > 0)
      begin
         for (k = 0; k < 20 && rx_valid !== 1'b1; k++) tick(1);
         chk("rx data", 32'(rx_data), 32'(exp_q.pop_front()));
         rx_ready = 1'b1;
         tick(1);
         rx_ready = 1'b0;
      end
      tick(2);
      chk("rx valid", 32'(rx_valid), 32'h0);
      // Aux pin into latch read, both levels
      for (k = 0; k < 2; k++)
      begin
         osc_aux_pin   = !k[0];
         latch_read_op = 1'b1;
         tick(1);
         latch_read_op = 1'b0;
         tick(1);
         chk("aux bit", 32'(latch_read_value[AUX_ACC_BIT]), 32'(!k[0]));
      end
      // Sync stopped, then a short and a full reset pulse
      sync_enable_clear = 1'b1;
      tick(1);
      sync_enable_clear = 1'b0;
      gap = 0;
      for (k = 0; k < 48; k++)
      begin
         tick(1);
         gap += int'(sync_clock_out === 1'b1);
      end
      chk("sync off", 32'(gap), 32'h0);
      reset_n = 1'b0;
      tick(10);
      reset_n = 1'b1;
      tick(2);
      chk("short reset", 32'(init_active), 32'h0);
      chk("enables", 32'(enables), 32'h4);
      reset_n = 1'b0;
      for (k = 0; k < 80 && init_active !== 1'b1; k++) tick(1);
      chk("init", 32'(init_active), 32'h1);
      chk("pc", 32'(pc), 32'(RESET_PC));
      chk("enables", 32'(enables), 32'h0);
      reset_n = 1'b1;
      for (k = 0; k < 80 && init_active !== 1'b0; k++) tick(1);
      measure(1'b1, gap);
      chk("sync gap", 32'(gap), 32'(DIV_16));
      // Interrupt on the plain copy: chain holds it off, then vector and return
      enables_value   = 4'h2;
      load_enables_op = 1'b1;
      tick(1);
      load_enables_op = 1'b0;
      irq_n           = 1'b0;
      tick(48);
      chk("port_oe float", 32'(oe_irq), 32'h0);
      {instr_done, instr_is_chain, instr_skip} = 3'b111;
      tick(1);
      instr_is_chain = 1'b0;
      chk("ack in chain", 32'(ack_irq), 32'h0);
      tick(1);
      instr_done = 1'b0;
      chk("ack", 32'(ack_irq), 32'h1);
      tick(1);
      instr_skip = 1'b0;
      chk("vector", 32'(pc_irq), 32'(IRQ_VECTOR));
      chk("irq enable", 32'(en_irq), 32'h0);
      {instr_done, stack_pop_op} = 2'b11;
      tick(1);
      {instr_done, stack_pop_op} = 2'b00;
      chk("return pc", 32'(pc_irq), 32'h2);
      chk("skip restore", 32'(skip_irq), 32'h1);
      end_of_test();
   end

endmodule
